//--- src/hww_regs.vh
/*
 * register offsets, field positions, reset values and timing counts
 * for the halt, wake-up and watchdog block. assumes a 40 MHz core clock.
 */
`ifndef HWW_REGS_VH
`define HWW_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HWW_OFF_WDOG_CTRL   12'h000
`define HWW_OFF_RST_FLAG    12'h004
`define HWW_OFF_SYS_CLK     12'h008
`define HWW_OFF_STATUS      12'h00c
`define HWW_OFF_PA_WAKE     12'h010

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define HWW_WDOG_CTRL_RST   8'h53
`define HWW_GE_DISABLE      5'h15
`define HWW_GE_ENABLE       5'h0a
`define HWW_RF_WDOG_BIT     0
`define HWW_RF_RCTL_BIT     3
`define HWW_SCC_KEEP_BIT    1
`define HWW_SCC_RST         8'h02
`define HWW_ST_PDF_BIT      0
`define HWW_ST_TO_BIT       1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define HWW_CLK_HZ          40000000
`define HWW_SUB_HZ          32000
`define HWW_SUB_DIV         (`HWW_CLK_HZ / `HWW_SUB_HZ)
`define HWW_SRESET_NS       1000
`define HWW_SRESET_CYC      ((`HWW_SRESET_NS * 40 + 999) / 1000)

`endif

//--- src/hww_halt_wake_wdog.v
/*
 * halt / wake-up arbitration and watchdog with an apb register slave.
 * assumes the core gives one-cycle halt and clear strobes on core_clk,
 * and that port a and the external reset pin are asynchronous.
 */
// The APB slave port and the address map are this design's own decisions.
// Contract
// - halt with keep-alive 0 enters sleep, clock stopped, core held at halt.
// - halt with keep-alive 1 enters idle, clocks run, core held.
// - entering sleep or idle disturbs no memory, register or port state.
// - entering sleep or idle clears watchdog; counts only when enabled.
// - halt sets power-down flag and clears time-out flag.
// - power-down flag cleared at power-up and by watchdog clear instruction.
// - wake on port a fall, external reset, interrupt or watchdog overflow.
// - reset wake resets all; watchdog wake sets time-out, resets pc and sp.
// - each port a pin has wake enable; resumes after halt.
// - disabled or stack-full interrupt wake resumes after halt; request stays pending.
// - enabled interrupt with free stack gets normal response on wake.
// - interrupt pending before halt cannot wake the device.
// - watchdog counts 32 kHz substitute clock divided by selected ratio.
// - watchdog control loads 0x53 on reset except watchdog wake reset.
// - enable field 10101 disables, 01010 enables, others request reset.
// - invalid enable field resets after fixed delay, sets software reset flag.
// - select 000..111 gives 2^8,10,12,14,15,16,-,18 periods.
// - reset flag bit 0 set by watchdog software reset, software clears only.
// - bit 3 holds reset-control flag, others read zero, both power up 0.
// - keep-alive is bit 1 of system clock control.
// - normal-mode watchdog time-out resets device and sets time-out flag.
// - watchdog clear instruction, halt and an invalid enable field are the software clears of the counter.
// - in sleep the substitute clock runs only while watchdog enabled.
`timescale 1ns/100ps
`default_nettype none
`include "hww_regs.vh"

module hww_halt_wake_wdog #(
    parameter PA_W       = 8,
    parameter SUB_DIV    = `HWW_SUB_DIV,
    parameter SRESET_CYC = `HWW_SRESET_CYC
) (
    input  wire            CORE_CLK_I,
    input  wire            RESET_N_I,
    input  wire            PSEL_I,
    input  wire            PENABLE_I,
    input  wire            PWRITE_I,
    input  wire [11:0]     PADDR_I,
    input  wire [31:0]     PWDATA_I,
    output wire [31:0]     PRDATA_O,
    output wire            PREADY_O,
    output wire            PSLVERR_O,
    input  wire            HALT_I,
    input  wire            WDOG_CLEAR_I,
    input  wire [PA_W-1:0] PORT_A_I,
    input  wire            EXT_RESET_N_I,
    input  wire            INT_REQ_I,
    input  wire            INT_ENABLED_I,
    input  wire            STACK_FULL_I,
    input  wire            RCTL_SW_RESET_I,
    output wire            SLEEP_O,
    output wire            IDLE_O,
    output wire            SYS_CLK_EN_O,
    output wire            SUB_CLK_EN_O,
    output wire            CORE_STALL_O,
    output wire            RESUME_O,
    output wire            INT_RESPOND_O,
    output wire            FULL_RESET_O,
    output wire            PC_SP_RESET_O
);

    // ----------------------------------------------------------------
    // state encoding and reset images
    // ----------------------------------------------------------------
    localparam ST_NORMAL = 3'b001;
    localparam ST_SLEEP  = 3'b010;
    localparam ST_IDLE   = 3'b100;
    localparam [7:0] SCC_RST = `HWW_SCC_RST;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    // third port a stage only feeds the falling-edge detector; pins idle
    // high, so the chain resets high and no false edge follows reset
    reg [PA_W-1:0] pa_s1_q, pa_s2_q, pa_s3_q;
    reg            xr_s1_q, xr_s2_q;
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pa_s1_q <= {PA_W{1'b1}};
            pa_s2_q <= {PA_W{1'b1}};
            pa_s3_q <= {PA_W{1'b1}};
            xr_s1_q <= 1'b1;
            xr_s2_q <= 1'b1;
        end else begin
            pa_s1_q <= PORT_A_I;
            pa_s2_q <= pa_s1_q;
            pa_s3_q <= pa_s2_q;
            xr_s1_q <= EXT_RESET_N_I;
            xr_s2_q <= xr_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    reg [2:0]      state_q;
    reg [7:0]      wctl_q;
    reg            wrf_q, reset_ctrl_sw_reset_flag_q, keep_q, pdf_q, to_q;
    reg [PA_W-1:0] port_a_wake_enable_q;
    reg            int_mask_q;
    reg [15:0]     pre_q;
    reg [17:0]     wcnt_q;
    reg [15:0]     srst_q;
    reg            srst_run_q;
    reg            full_rst_q, pcsp_rst_q, resume_q, int_resp_q;

    wire [4:0] ge     = wctl_q[7:3];
    wire       wd_en  = (ge == `HWW_GE_ENABLE);
    wire       ge_bad = (ge != `HWW_GE_ENABLE) && (ge != `HWW_GE_DISABLE);
    wire       asleep = (state_q != ST_NORMAL);

    // time-out period as highest counter index
    // code 110 is undefined; treated as 2^17 until confirmed
    function [17:0] wd_limit;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: wd_limit = 18'h000ff;
                3'h1: wd_limit = 18'h003ff;
                3'h2: wd_limit = 18'h00fff;
                3'h3: wd_limit = 18'h03fff;
                3'h4: wd_limit = 18'h07fff;
                3'h5: wd_limit = 18'h0ffff;
                3'h6: wd_limit = 18'h1ffff;
                default: wd_limit = 18'h3ffff;
            endcase
        end
    endfunction

    // one-cycle substitute clock tick every SUB_DIV core clocks
    wire sub_tick = (pre_q == SUB_DIV[15:0] - 16'h1);
    wire wd_ovf   = wd_en && sub_tick && (wcnt_q == wd_limit(wctl_q[2:0]));

    // ----------------------------------------------------------------
    // wake sources
    // ----------------------------------------------------------------
    // an interrupt raised before halt stays masked until it drops
    wire pa_wake  = |(port_a_wake_enable_q & pa_s3_q & ~pa_s2_q);
    wire int_wake = INT_REQ_I && !int_mask_q;
    // level, so a pin held low keeps the full reset asserted
    wire xr_wake  = !xr_s2_q;
    wire srst_fire = srst_run_q && (srst_q == SRESET_CYC[15:0] - 16'h1);
    wire halt_go  = HALT_I && !asleep;

    // ----------------------------------------------------------------
    // apb slave: zero wait states
    // ----------------------------------------------------------------
    // unmapped offsets read zero and raise an error; nothing is written
    wire       wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    reg        bad_addr;
    reg [31:0] rd_mux;
    reg [31:0] prdata_q;
    always @* begin
        bad_addr = 1'b0;
        rd_mux   = 32'h0;
        if (PADDR_I == `HWW_OFF_WDOG_CTRL) begin
            rd_mux = {24'h0, wctl_q};
        end else if (PADDR_I == `HWW_OFF_RST_FLAG) begin
            rd_mux = {28'h0, reset_ctrl_sw_reset_flag_q, 2'b00, wrf_q};
        end else if (PADDR_I == `HWW_OFF_SYS_CLK) begin
            rd_mux = {30'h0, keep_q, 1'b0};
        end else if (PADDR_I == `HWW_OFF_STATUS) begin
            rd_mux = {29'h0, state_q == ST_IDLE, to_q, pdf_q};
        end else if (PADDR_I == `HWW_OFF_PA_WAKE) begin
            rd_mux = {{(32-PA_W){1'b0}}, port_a_wake_enable_q};
        end else begin
            bad_addr = 1'b1;
        end
    end
    assign PRDATA_O  = prdata_q;
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && bad_addr;

    wire wr_ok = wr_acc && !bad_addr;

    // ----------------------------------------------------------------
    // read data register
    // ----------------------------------------------------------------
    // taken in the setup cycle so the access still needs no wait state;
    // a flag that sets during the access shows on the next read
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            prdata_q <= 32'h0;
        end else if (PSEL_I && !PENABLE_I) begin
            prdata_q <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // main sequential logic
    // ----------------------------------------------------------------
    always @(posedge CORE_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q    <= ST_NORMAL;
            wctl_q     <= `HWW_WDOG_CTRL_RST;
            wrf_q      <= 1'b0;
            reset_ctrl_sw_reset_flag_q     <= 1'b0;
            keep_q     <= SCC_RST[`HWW_SCC_KEEP_BIT];
            pdf_q      <= 1'b0;
            to_q       <= 1'b0;
            port_a_wake_enable_q     <= {PA_W{1'b0}};
            int_mask_q <= 1'b0;
            pre_q      <= 16'h0;
            wcnt_q     <= 18'h0;
            srst_q     <= 16'h0;
            srst_run_q <= 1'b0;
            full_rst_q <= 1'b0;
            pcsp_rst_q <= 1'b0;
            resume_q   <= 1'b0;
            int_resp_q <= 1'b0;
        end else begin
            full_rst_q <= 1'b0;
            pcsp_rst_q <= 1'b0;
            resume_q   <= 1'b0;
            int_resp_q <= 1'b0;

            // substitute clock prescaler, gated off in sleep when disabled
            if (state_q == ST_SLEEP && !wd_en) begin
                pre_q <= 16'h0;
            end else if (sub_tick) begin
                pre_q <= 16'h0;
            end else begin
                pre_q <= pre_q + 16'h1;
            end

            // watchdog counter, cleared only by halt, clear strobe, an invalid enable field, overflow or reset
            if (halt_go || WDOG_CLEAR_I || ge_bad) begin
                wcnt_q <= 18'h0;
            end else if (wd_en && sub_tick) begin
                wcnt_q <= wd_ovf ? 18'h0 : wcnt_q + 18'h1;
            end

            // register writes
            if (wr_ok && PADDR_I == `HWW_OFF_WDOG_CTRL) begin
                wctl_q <= PWDATA_I[7:0];
            end
            if (wr_ok && PADDR_I == `HWW_OFF_SYS_CLK) begin
                keep_q <= PWDATA_I[`HWW_SCC_KEEP_BIT];
            end
            if (wr_ok && PADDR_I == `HWW_OFF_PA_WAKE) begin
                port_a_wake_enable_q <= PWDATA_I[PA_W-1:0];
            end
            if (RCTL_SW_RESET_I) begin
                reset_ctrl_sw_reset_flag_q <= 1'b1;
            end else if (wr_ok && PADDR_I == `HWW_OFF_RST_FLAG) begin
                reset_ctrl_sw_reset_flag_q <= PWDATA_I[`HWW_RF_RCTL_BIT];
            end

            // invalid enable field: delayed software reset
            // a good value written meanwhile does not cancel it
            if (ge_bad && !srst_run_q) begin
                srst_run_q <= 1'b1;
                srst_q     <= 16'h0;
            end else if (srst_run_q) begin
                srst_q <= srst_q + 16'h1;
            end

            // set beats software clear
            if (srst_fire) begin
                wrf_q <= 1'b1;
            end else if (wr_ok && PADDR_I == `HWW_OFF_RST_FLAG && !PWDATA_I[`HWW_RF_WDOG_BIT]) begin
                wrf_q <= 1'b0;
            end

            // the time-out flag clears together with the power-down flag
            if (WDOG_CLEAR_I) begin
                pdf_q <= 1'b0;
                to_q  <= 1'b0;
            end

            case (state_q)
                ST_NORMAL: begin
                    if (xr_wake || srst_fire || wd_ovf) begin
                        // whole-device reset, control reloads
                        full_rst_q <= 1'b1;
                        wctl_q     <= `HWW_WDOG_CTRL_RST;
                        srst_run_q <= 1'b0;
                        wcnt_q     <= 18'h0;
                        if (wd_ovf) begin
                            to_q <= 1'b1;
                        end
                    end else if (halt_go) begin
                        pdf_q      <= 1'b1;
                        to_q       <= 1'b0;
                        int_mask_q <= INT_REQ_I;
                        state_q    <= keep_q ? ST_IDLE : ST_SLEEP;
                    end
                end
                ST_SLEEP, ST_IDLE: begin
                    // priority: resets, overflow, interrupt, then port a
                    // re-arm the interrupt wake once the pending request drops
                    if (!INT_REQ_I) begin
                        int_mask_q <= 1'b0;
                    end
                    if (xr_wake || srst_fire) begin
                        full_rst_q <= 1'b1;
                        wctl_q     <= `HWW_WDOG_CTRL_RST;
                        srst_run_q <= 1'b0;
                        pdf_q      <= 1'b0;
                        state_q    <= ST_NORMAL;
                    end else if (wd_ovf) begin
                        // control register kept on this path
                        to_q       <= 1'b1;
                        pcsp_rst_q <= 1'b1;
                        state_q    <= ST_NORMAL;
                    end else if (int_wake) begin
                        if (INT_ENABLED_I && !STACK_FULL_I) begin
                            int_resp_q <= 1'b1;
                        end else begin
                            resume_q   <= 1'b1;
                        end
                        state_q <= ST_NORMAL;
                    end else if (pa_wake) begin
                        resume_q <= 1'b1;
                        state_q  <= ST_NORMAL;
                    end
                end
                default: state_q <= ST_NORMAL;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs; core state is stalled, and touched only by the reset strobes
    // ----------------------------------------------------------------
    assign SLEEP_O       = (state_q == ST_SLEEP);
    assign IDLE_O        = (state_q == ST_IDLE);
    assign SYS_CLK_EN_O  = (state_q != ST_SLEEP);
    assign SUB_CLK_EN_O  = (state_q != ST_SLEEP) || wd_en;
    assign CORE_STALL_O  = asleep;
    // wake and reset strobes are registered one-clock pulses; full reset stays high while the reset pin is held low
    assign RESUME_O      = resume_q;
    assign INT_RESPOND_O = int_resp_q;
    assign FULL_RESET_O  = full_rst_q;
    assign PC_SP_RESET_O = pcsp_rst_q;

endmodule
`default_nettype wire

//--- testbench/hww_checker.sv
/* concurrent checks on the halt, wake-up and watchdog block ports.
   assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
module hww_checker (
    input wire logic CORE_CLK_I,
    input wire logic RESET_N_I,
    input wire logic HALT_I,
    input wire logic EXT_RESET_N_I,
    input wire logic INT_ENABLED_I,
    input wire logic STACK_FULL_I,
    input wire logic SLEEP_O,
    input wire logic IDLE_O,
    input wire logic SYS_CLK_EN_O,
    input wire logic SUB_CLK_EN_O,
    input wire logic CORE_STALL_O,
    input wire logic RESUME_O,
    input wire logic INT_RESPOND_O,
    input wire logic FULL_RESET_O,
    input wire logic PC_SP_RESET_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    wire rest = SLEEP_O || IDLE_O;
    // ----------------------------------------------------------------
    // sequences
    // ----------------------------------------------------------------
    sequence s_halt;
        HALT_I && !rest && EXT_RESET_N_I;
    endsequence
    sequence s_ext_wake;
        rest && $fell(EXT_RESET_N_I);
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_halt_enters_rest: assert property (s_halt |=> (SLEEP_O ^ IDLE_O) && CORE_STALL_O)
        else $error("halt did not enter exactly one low-power state");
    a_sleep_clock_off: assert property (SLEEP_O |-> !SYS_CLK_EN_O && !IDLE_O)
        else $error("system clock running in sleep");
    a_idle_clocks_on: assert property (IDLE_O |-> SYS_CLK_EN_O && SUB_CLK_EN_O)
        else $error("clock stopped in idle");
    a_rest_stalls_core: assert property (rest |-> CORE_STALL_O)
        else $error("core not held while resting");
    a_ext_reset_wake: assert property (s_ext_wake |-> ##[1:5] FULL_RESET_O)
        else $error("external reset did not wake with full reset");
    a_resume_leaves: assert property (RESUME_O |-> $past(rest) && !rest)
        else $error("resume pulse without leaving rest");
    a_int_respond_ok: assert property (INT_RESPOND_O |-> $past(rest) && $past(INT_ENABLED_I) && !$past(STACK_FULL_I))
        else $error("interrupt response while disabled or stack full");
    a_pcsp_from_rest: assert property (PC_SP_RESET_O |-> $past(rest) && !rest)
        else $error("partial reset outside rest");
endmodule
`default_nettype wire

//--- testbench/hww_core_model.sv
/* processor core stand-in: turns bench requests into halt and clear strobes.
   assumes one-cycle requests on the core clock. */
`timescale 1ns/100ps
`default_nettype none
module hww_core_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic halt_req_i,
    input  wire logic clr_req_i,
    input  wire logic stall_i,
    output var  logic halt_o,
    output var  logic clear_o
);
    // a stalled core executes nothing, so it cannot strobe either
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            halt_o  <= 1'b0;
            clear_o <= 1'b0;
        end else begin
            halt_o  <= halt_req_i && !stall_i;
            clear_o <= clr_req_i && !stall_i;
        end
    end
endmodule
`default_nettype wire

//--- testbench/hww_halt_wake_wdog_test.sv
/* self-checking bench for the halt, wake-up and watchdog block.
   assumes short divider and soft reset delay for run time. */
`timescale 1ns/100ps
`default_nettype none
`include "hww_regs.vh"
module hww_halt_wake_wdog_test;
    localparam logic [11:0] WC = `HWW_OFF_WDOG_CTRL, RF = `HWW_OFF_RST_FLAG, SC = `HWW_OFF_SYS_CLK;
    localparam logic [11:0] ST = `HWW_OFF_STATUS, PW = `HWW_OFF_PA_WAKE;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic ext_n = 1, int_req = 0, int_en = 0, stk_full = 0, rctl = 0, halt_req = 0, clr_req = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, rd;
    logic [7:0]  port_a = 8'hff;
    wire  [31:0] prdata;
    wire pready, pslverr, halt, wclr, sleep, idle, sys_en, sub_en, stall, resume, int_rsp, full_rst, pcsp;
    wire  [3:0]  evt = {full_rst, pcsp, resume, int_rsp};
    int num_errors = 0, checks_done = 0, n;
    always #12.5 clk = ~clk;
    hww_core_model core_u (.clk_i(clk), .rst_n_i(rst_n), .halt_req_i(halt_req), .clr_req_i(clr_req),
        .stall_i(stall), .halt_o(halt), .clear_o(wclr));
    hww_halt_wake_wdog #(.PA_W(8), .SUB_DIV(2), .SRESET_CYC(8)) dut_u (
        .CORE_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .HALT_I(halt), .WDOG_CLEAR_I(wclr), .PORT_A_I(port_a), .EXT_RESET_N_I(ext_n), .INT_REQ_I(int_req),
        .INT_ENABLED_I(int_en), .STACK_FULL_I(stk_full), .RCTL_SW_RESET_I(rctl), .SLEEP_O(sleep),
        .IDLE_O(idle), .SYS_CLK_EN_O(sys_en), .SUB_CLK_EN_O(sub_en), .CORE_STALL_O(stall),
        .RESUME_O(resume), .INT_RESPOND_O(int_rsp), .FULL_RESET_O(full_rst), .PC_SP_RESET_O(pcsp));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (w >= 20) begin
            num_errors++;
            $display("BAD t=%0t bus hung", $time);
            give_verdict();
        end
    endtask
    // waits for one of the result pulses, counting edges
    task automatic wait_evt(input int k, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (evt[k] !== 1'b1 && n < lim);
        if (n >= lim) begin
            num_errors++;
            $display("BAD t=%0t pulse never came", $time);
            give_verdict();
        end
    endtask
    task automatic core(input logic h);
        @(posedge clk);
        if (h) begin
            halt_req <= 1'b1;
        end else begin
            clr_req <= 1'b1;
        end
        @(posedge clk);
        halt_req <= 1'b0;
        clr_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        apb(0, WC, 0);
        chk(rd, 32'h53);
        apb(0, RF, 0);
        chk(rd, 32'h00);
        apb(0, SC, 0);
        chk(rd, 32'h02);
        apb(0, ST, 0);
        chk(rd, 32'h00);
        apb(1, RF, 32'hf6);
        apb(0, RF, 0);
        chk(rd, 32'h00);
        apb(0, 12'h014, 0);
        chk(err, 1'b1);
        chk(rd, 32'h00);
        apb(1, WC, 32'hab);
        apb(0, WC, 0);
        chk(rd, 32'hab);
        $display("registers done");
    endtask
    task automatic t_sleep_port();
        apb(1, SC, 0);
        apb(1, PW, 32'h02);
        apb(0, PW, 0);
        chk(rd, 32'h02);
        core(1);
        chk({sleep, sys_en, sub_en}, 3'b100);
        repeat (600) @(posedge clk);
        chk(sleep, 1);
        port_a <= 8'hfe;
        repeat (10) @(posedge clk);
        chk(sleep, 1);
        port_a <= 8'hfc;
        wait_evt(1, 12);
        @(posedge clk);
        chk({sleep, port_a}, 9'h0fc);
        port_a <= 8'hff;
        $display("port wake done");
    endtask
    task automatic t_sleep_wdog();
        apb(1, WC, 32'h50);
        core(1);
        chk(sub_en, 1);
        wait_evt(2, 700);
        chk(n >= 500 && n <= 520, 1);
        apb(0, ST, 0);
        chk(rd[1:0], 2'b11);
        apb(0, WC, 0);
        chk(rd, 32'h50);
        apb(1, WC, 32'hab);
        apb(1, SC, 32'h02);
        $display("sleep overflow done");
    endtask
    task automatic t_idle_int();
        core(1);
        chk({idle, sys_en}, 2'b11);
        apb(0, ST, 0);
        chk(rd[2:0], 3'b101);
        int_en <= 1'b1;
        int_req <= 1'b1;
        wait_evt(0, 20);
        int_req <= 1'b0;
        core(0);
        apb(0, ST, 0);
        chk(rd[1:0], 2'b00);
        $display("idle interrupt done");
    endtask
    task automatic t_pending();
        int_en <= 1'b0;
        int_req <= 1'b1;
        core(1);
        repeat (20) @(posedge clk);
        chk(idle, 1);
        int_req <= 1'b0;
        repeat (2) @(posedge clk);
        int_req <= 1'b1;
        int_en <= 1'b1;
        stk_full <= 1'b1;
        wait_evt(1, 20);
        int_req <= 1'b0;
        stk_full <= 1'b0;
        $display("pending interrupt done");
    endtask
    task automatic t_normal_wdog();
        apb(1, WC, 32'h51);
        core(0);
        wait_evt(3, 2200);
        chk(n >= 2030 && n <= 2060, 1);
        apb(0, ST, 0);
        chk(rd[1], 1);
        apb(0, WC, 0);
        chk(rd, 32'h53);
        $display("normal overflow done");
    endtask
    task automatic t_bad_field();
        apb(1, WC, 32'hfb);
        wait_evt(3, 30);
        chk(n >= 6 && n <= 12, 1);
        apb(0, RF, 0);
        chk(rd, 32'h01);
        apb(0, WC, 0);
        chk(rd, 32'h53);
        apb(1, RF, 0);
        apb(0, RF, 0);
        chk(rd, 32'h00);
        rctl <= 1'b1;
        @(posedge clk);
        rctl <= 1'b0;
        apb(0, RF, 0);
        chk(rd, 32'h08);
        apb(1, RF, 0);
        core(1);
        ext_n <= 1'b0;
        wait_evt(3, 10);
        ext_n <= 1'b1;
        $display("soft and external reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_sleep_port();
        t_sleep_wdog();
        t_idle_int();
        t_pending();
        t_normal_wdog();
        t_bad_field();
        give_verdict();
    end
endmodule
bind hww_halt_wake_wdog hww_checker chk_u (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .HALT_I(HALT_I),
    .EXT_RESET_N_I(EXT_RESET_N_I), .INT_ENABLED_I(INT_ENABLED_I), .STACK_FULL_I(STACK_FULL_I),
    .SLEEP_O(SLEEP_O), .IDLE_O(IDLE_O), .SYS_CLK_EN_O(SYS_CLK_EN_O), .SUB_CLK_EN_O(SUB_CLK_EN_O),
    .CORE_STALL_O(CORE_STALL_O), .RESUME_O(RESUME_O), .INT_RESPOND_O(INT_RESPOND_O),
    .FULL_RESET_O(FULL_RESET_O), .PC_SP_RESET_O(PC_SP_RESET_O));
`default_nettype wire
